// file: verilog/swm_top.v
// Receive FIFO and command interpreter for block write and monitor registration.
`timescale 1ns/100ps
`include "swm_consts.vh"

// ********************************************************************
// Receive FIFO
// ********************************************************************
module swm_fifo #(
  parameter WIDTH = `SWM_FIFO_W,
  parameter DEPTH = `SWM_FIFO_D,
  parameter AW    = `SWM_FIFO_AW
) (
  input  wire             sys_clk,
  input  wire             rst_b,
  input  wire [WIDTH-1:0] in_data,
  input  wire             in_valid,
  output reg              in_ready,
  output wire [WIDTH-1:0] out_data,
  output wire             out_valid,
  input  wire             out_ready
);
  reg  [WIDTH-1:0] mem [0:DEPTH-1];
  reg  [AW-1:0]    wr_q;
  reg  [AW-1:0]    rd_q;
  reg  [AW:0]      cnt_q;
  wire             push;
  wire             pop;
  wire [AW:0]      cnt_d;

  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign out_data  = mem[rd_q];
  assign cnt_d     = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

  // Ready is registered from the next count so it never glitches on pop.
  always @(posedge sys_clk) begin
    if (!rst_b) begin
      wr_q     <= {AW{1'b0}};
      rd_q     <= {AW{1'b0}};
      cnt_q    <= {(AW+1){1'b0}};
      in_ready <= 1'b0;
    end else begin
      if (push) begin
        mem[wr_q] <= in_data;
        wr_q      <= wr_q + 1'b1;
      end
      if (pop)
        rd_q <= rd_q + 1'b1;
      cnt_q    <= cnt_d;
      in_ready <= (cnt_d != DEPTH[AW:0]);
    end
  end
endmodule // swm_fifo

// ********************************************************************
// Command interpreter
// ********************************************************************
module swm_top (
  input  wire       sys_clk,
  input  wire       rst_b,
  input  wire [7:0] station_id,
  input  wire [7:0] rx_data,
  input  wire       rx_valid,
  output wire       rx_ready,
  output reg  [7:0] tx_data,
  output reg        tx_valid,
  input  wire       tx_ready,
  input  wire [3:0] query_slot,
  output reg        query_used,
  output reg        query_is_ind,
  output reg  [7:0] query_count,
  output reg  [7:0] query_name_len
);
  localparam S_IDLE = 9'h001;
  localparam S_STN  = 9'h002;
  localparam S_CMD  = 9'h004;
  localparam S_HDR2 = 9'h008;
  localparam S_BODY = 9'h010;
  localparam S_BCC  = 9'h020;
  localparam S_SKIP = 9'h040;
  localparam S_DEC  = 9'h080;
  localparam S_RESP = 9'h100;

  // Hex character to nibble; bit 4 flags a legal hex digit.
  function [4:0] hex2nib;
    input [7:0] c;
    begin
      if (c >= 8'h30 && c <= 8'h39)
        hex2nib = {1'b1, c[3:0]};
      else if ((c >= 8'h41 && c <= 8'h46) || (c >= 8'h61 && c <= 8'h66))
        hex2nib = {1'b1, c[3:0] + 4'h9};
      else
        hex2nib = 5'h00;
    end
  endfunction

  // Nibble to upper-case hex character.
  function [7:0] nib2hex;
    input [3:0] n;
    begin
      nib2hex = (n < 4'hA) ? {4'h3, n} : {4'h4, n - 4'h9};
    end
  endfunction

  wire [7:0] f_data;
  wire       f_valid;
  wire       f_ready;
  wire       take;
  wire [4:0] hn;

  swm_fifo #(
    .WIDTH (`SWM_FIFO_W),
    .DEPTH (`SWM_FIFO_D),
    .AW    (`SWM_FIFO_AW)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .rst_b     (rst_b),
    .in_data   (rx_data),
    .in_valid  (rx_valid),
    .in_ready  (rx_ready),
    .out_data  (f_data),
    .out_valid (f_valid),
    .out_ready (f_ready)
  );

  reg  [8:0]  st_q;
  reg         cnt_q;
  reg  [15:0] stn_q;
  reg  [7:0]  cmd_q;
  reg  [15:0] f_q;
  reg  [7:0]  sum_q;
  reg  [8:0]  pos_q;
  reg  [23:0] tag_q;
  reg  [7:0]  v1_q;
  reg  [7:0]  v2_q;
  reg         hexbad_q;
  reg  [3:0]  bhi_q;
  reg         bccbad_q;
  reg         nak_q;
  reg  [15:0] err_q;
  reg  [3:0]  ridx_q;
  reg  [7:0]  tsum_q;
  reg  [15:0] slot_used_q;
  reg         slot_ind_q [0:15];
  reg  [7:0]  slot_cnt_q [0:15];
  reg  [7:0]  slot_len_q [0:15];
  reg  [15:0] err_w;
  reg  [7:0]  rbyte_w;
  integer     i;

  // The FIFO is drained only while no answer is being sent, which stalls the source.
  assign f_ready = (st_q != S_RESP) && (st_q != S_DEC);
  assign take    = f_valid & f_ready;
  assign hn      = hex2nib(f_data);

  wire        lower   = cmd_q[`SWM_LOWER_BIT];
  wire        is_reg  = ((cmd_q & 8'hDF) == `SWM_CMD_REG);
  wire [4:0]  shi     = hex2nib(f_q[15:8]);
  wire [4:0]  slo     = hex2nib(f_q[7:0]);
  wire [7:0]  slot_v  = {shi[3:0], slo[3:0]};
  wire [9:0]  pos_x   = {1'b0, pos_q};
  wire [9:0]  wneed   = 10'd4 + {2'b00, v1_q}; // Length, name and item count ahead of data.
  wire [15:0] typ_w   = is_reg ? f_q : `SWM_TYPE_BLK; // Block write always answers its type.
  wire [3:0]  etx_idx = nak_q ? 4'd10 : 4'd6;
  wire [3:0]  last    = lower ? etx_idx + 4'd2 : etx_idx;

  // Verdict on the finished request; a bad check sum outranks field errors.
  always @* begin
    err_w = 16'h0000;
    if (bccbad_q) begin
      err_w = `SWM_ERR_BCC;
    end else if (hexbad_q) begin
      err_w = `SWM_ERR_FIELD;
    end else if (is_reg) begin
      if (!shi[4] || !slo[4] || slot_v > `SWM_SLOT_MAX)
        err_w = `SWM_ERR_SLOT;
      else if (tag_q == `SWM_TAG_IND) begin
        if (v1_q > `SWM_BLK_MAX || v1_q == 8'h00)
          err_w = `SWM_ERR_SIZE;
        else if (v2_q < `SWM_NAME_MIN || v2_q > `SWM_NAME_MAX || pos_q < 9'd7)
          err_w = `SWM_ERR_FIELD;
      end else if (tag_q == `SWM_TAG_CON) begin
        if (v1_q < `SWM_NAME_MIN || v1_q > `SWM_NAME_MAX)
          err_w = `SWM_ERR_FIELD;
        else if (pos_x <= 10'd5 + {2'b00, v1_q})
          err_w = `SWM_ERR_FIELD;
      end else begin
        err_w = `SWM_ERR_TAG;
      end
    end else begin
      if (f_q != `SWM_TYPE_BLK)
        err_w = `SWM_ERR_TAG;
      else if (v1_q < `SWM_NAME_MIN || v1_q > `SWM_NAME_MAX)
        err_w = `SWM_ERR_FIELD;
      else if (pos_x < wneed || (pos_x - wneed) > `SWM_DATA_MAX)
        err_w = `SWM_ERR_SIZE;
    end
  end

  // Byte of the answer frame at position ridx_q.
  always @* begin
    case (ridx_q)
      4'd0: rbyte_w = nak_q ? `SWM_NAK : `SWM_ACK;
      4'd1: rbyte_w = stn_q[15:8];
      4'd2: rbyte_w = stn_q[7:0];
      4'd3: rbyte_w = cmd_q;
      4'd4: rbyte_w = typ_w[15:8];
      4'd5: rbyte_w = typ_w[7:0];
      default: begin
        if (ridx_q == etx_idx)
          rbyte_w = `SWM_ETX;
        else if (ridx_q == etx_idx + 4'd1)
          rbyte_w = nib2hex(tsum_q[7:4]);
        else if (ridx_q == etx_idx + 4'd2)
          rbyte_w = nib2hex(tsum_q[3:0]);
        else
          rbyte_w = nib2hex(err_q[15 - 4 * (ridx_q - 4'd6) -: 4]);
      end
    endcase
  end

  // Request parser, slot store and answer sequencer.
  always @(posedge sys_clk) begin
    if (!rst_b) begin
      st_q        <= S_IDLE;
      cnt_q       <= 1'b0;
      stn_q       <= 16'h0000;
      cmd_q       <= 8'h00;
      f_q         <= 16'h0000;
      sum_q       <= 8'h00;
      pos_q       <= 9'h000;
      tag_q       <= 24'h000000;
      v1_q        <= 8'h00;
      v2_q        <= 8'h00;
      hexbad_q    <= 1'b0;
      bhi_q       <= 4'h0;
      bccbad_q    <= 1'b0;
      nak_q       <= 1'b0;
      err_q       <= 16'h0000;
      ridx_q      <= 4'h0;
      tsum_q      <= 8'h00;
      tx_data     <= 8'h00;
      tx_valid    <= 1'b0;
      slot_used_q <= 16'h0000;
      for (i = 0; i < 16; i = i + 1) begin
        slot_ind_q[i] <= 1'b0;
        slot_cnt_q[i] <= 8'h00;
        slot_len_q[i] <= 8'h00;
      end
    end else begin
      // Running sum of the request; the received check characters stay out of it.
      if (take && st_q != S_BCC)
        sum_q <= sum_q + f_data;
      case (st_q)
        S_IDLE: begin
          if (take && f_data == `SWM_ENQ) begin
            st_q     <= S_STN;
            sum_q    <= `SWM_ENQ;
            cnt_q    <= 1'b0;
            pos_q    <= 9'h000;
            hexbad_q <= 1'b0;
            bccbad_q <= 1'b0;
            tag_q    <= 24'h000000;
            v1_q     <= 8'h00;
            v2_q     <= 8'h00;
          end
        end
        S_STN: begin
          if (take) begin
            stn_q <= {stn_q[7:0], f_data};
            cnt_q <= ~cnt_q;
            if (f_data == `SWM_EOT)
              st_q <= S_IDLE;
            else if (cnt_q) begin
              // A frame for another station is swallowed without an answer.
              if (hex2nib(stn_q[7:0]) == {1'b1, station_id[7:4]} &&
                  hn == {1'b1, station_id[3:0]})
                st_q <= S_CMD;
              else
                st_q <= S_SKIP;
            end
          end
        end
        S_CMD: begin
          if (take) begin
            cmd_q <= f_data;
            cnt_q <= 1'b0;
            if ((f_data & 8'hDF) == `SWM_CMD_WRITE || (f_data & 8'hDF) == `SWM_CMD_REG)
              st_q <= S_HDR2;
            else
              st_q <= (f_data == `SWM_EOT) ? S_IDLE : S_SKIP;
          end
        end
        S_HDR2: begin
          if (take) begin
            f_q   <= {f_q[7:0], f_data};
            cnt_q <= ~cnt_q;
            if (f_data == `SWM_EOT)
              st_q <= S_IDLE;
            else if (cnt_q)
              st_q <= S_BODY;
          end
        end
        S_BODY: begin
          if (take) begin
            if (f_data == `SWM_EOT) begin
              cnt_q <= 1'b0;
              st_q  <= lower ? S_BCC : S_DEC;
            end else begin
              if (pos_q != 9'h1FF)
                pos_q <= pos_q + 9'h001;
              if (is_reg) begin
                if (pos_q < 9'd3)
                  tag_q <= {tag_q[15:0], f_data};
                else if (pos_q < 9'd5)
                  v1_q <= {v1_q[3:0], hn[3:0]};
                else if (pos_q < 9'd7)
                  v2_q <= {v2_q[3:0], hn[3:0]};
                if (pos_q >= 9'd3 && pos_q < 9'd5 && !hn[4])
                  hexbad_q <= 1'b1;
              end else begin
                if (pos_q < 9'd2) begin
                  v1_q <= {v1_q[3:0], hn[3:0]};
                  if (!hn[4])
                    hexbad_q <= 1'b1;
                end
              end
            end
          end
        end
        S_BCC: begin
          if (take) begin
            cnt_q <= ~cnt_q;
            bhi_q <= hn[3:0];
            if (!hn[4])
              bccbad_q <= 1'b1;
            if (cnt_q) begin
              // The sum already holds everything from ENQ through EOT.
              if ({bhi_q, hn[3:0]} != sum_q)
                bccbad_q <= 1'b1;
              st_q <= S_DEC;
            end
          end
        end
        S_SKIP: begin
          if (take && f_data == `SWM_EOT)
            st_q <= S_IDLE;
        end
        S_DEC: begin
          nak_q  <= (err_w != 16'h0000);
          err_q  <= err_w;
          ridx_q <= 4'h0;
          tsum_q <= 8'h00;
          st_q   <= S_RESP;
          // Only a fully good registration touches the store; it overwrites.
          if (is_reg && err_w == 16'h0000) begin
            slot_used_q[slot_v[3:0]] <= 1'b1;
            slot_ind_q[slot_v[3:0]]  <= (tag_q == `SWM_TAG_IND);
            slot_cnt_q[slot_v[3:0]]  <= (tag_q == `SWM_TAG_IND) ? v1_q : 8'h00;
            slot_len_q[slot_v[3:0]]  <= (tag_q == `SWM_TAG_IND) ? v2_q : v1_q;
          end
        end
        S_RESP: begin
          if (!tx_valid || tx_ready) begin
            if (ridx_q <= last) begin
              tx_data  <= rbyte_w;
              tx_valid <= 1'b1;
              ridx_q   <= ridx_q + 4'h1;
              if (ridx_q <= etx_idx)
                tsum_q <= tsum_q + rbyte_w;
            end else begin
              tx_valid <= 1'b0;
              st_q     <= S_IDLE;
            end
          end
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end

  // Lookup port for the later execution step.
  always @(posedge sys_clk) begin
    if (!rst_b) begin
      query_used     <= 1'b0;
      query_is_ind   <= 1'b0;
      query_count    <= 8'h00;
      query_name_len <= 8'h00;
    end else begin
      query_used     <= slot_used_q[query_slot];
      query_is_ind   <= slot_ind_q[query_slot];
      query_count    <= slot_cnt_q[query_slot];
      query_name_len <= slot_len_q[query_slot];
    end
  end
endmodule // swm_top

// file: verilog/swm_consts.vh
// Constants for the serial write and monitor-registration command interpreter.
//
// Behaviour
// - Rejected block write answers NAK, station, letter, type, code.
// - Error code sent as four hex characters.
// - Lowercase reject frame appends NAK-to-ETX sum.
// - Lowercase accept frame appends ACK-to-ETX sum.
// - Registration request is ENQ, station, letter, number, body, EOT.
// - Sixteen slots, numbered 00 to 0F in hex.
// - Registering an occupied slot replaces its entry.
// - Stored entries are kept for later execution by slot.
// - Individual body: tag, block count, name length, name.
// - More than sixteen blocks is invalid.
// - Consecutive body: tag, name length, name, item count.
// - Good registration answers ACK, station, letter, number, ETX.
// - Failed registration answers NAK with four-character code.
// - Block write data above 120 bytes is rejected.
// - Name length must lie between 01 and 10 hex.
`ifndef SWM_CONSTS_VH
`define SWM_CONSTS_VH

// Control characters of the framing.
`define SWM_ENQ       8'h05
`define SWM_ACK       8'h06
`define SWM_NAK       8'h15
`define SWM_EOT       8'h04
`define SWM_ETX       8'h03

// Command letters (upper case; bit 5 set marks the checked form).
`define SWM_CMD_WRITE 8'h57
`define SWM_CMD_REG   8'h58
`define SWM_LOWER_BIT 5
`define SWM_TYPE_BLK  16'h5342
`define SWM_TAG_IND   24'h525353
`define SWM_TAG_CON   24'h525342

// Limits.
`define SWM_NAME_MIN  8'h01
`define SWM_NAME_MAX  8'h10
`define SWM_BLK_MAX   8'h10
`define SWM_SLOT_MAX  8'h0F
`define SWM_DATA_MAX  10'd240

// Error codes sent in reject frames.
`define SWM_ERR_BCC   16'h0001
`define SWM_ERR_FIELD 16'h0002
`define SWM_ERR_SLOT  16'h0003
`define SWM_ERR_SIZE  16'h0004
`define SWM_ERR_TAG   16'h0005

// Receive buffer shape.
`define SWM_FIFO_W    8
`define SWM_FIFO_D    8
`define SWM_FIFO_AW   3

`endif

// file: verif/swm_monitor.sv
// Checker of the answer framing seen at the ports of the command interpreter.
`timescale 1ns/100ps
`include "swm_consts.vh"

// ********************************************************************
// Answer framing checker
// ********************************************************************
module swm_monitor (
  input wire       sys_clk,
  input wire       rst_b,
  input wire       rx_ready,
  input wire [7:0] tx_data,
  input wire       tx_valid,
  input wire       tx_ready,
  input wire       query_used
);
  reg  [3:0] n_q;
  reg  [7:0] hd_q;
  wire       hs  = tx_valid & tx_ready;
  wire       hdr = (tx_data == `SWM_ACK) | (tx_data == `SWM_NAK);
  wire       hx  = (tx_data >= 8'h30 && tx_data <= 8'h39) || (tx_data >= 8'h41 && tx_data <= 8'h46);

  // Byte index within the answer; header bytes never occur inside a frame, so they resync it.
  always @(posedge sys_clk) begin
    if (!rst_b) begin
      n_q  <= 4'h0;
      hd_q <= 8'h00;
    end else if (hs && hdr) begin
      n_q  <= 4'h0;
      hd_q <= tx_data;
    end else if (hs) begin
      n_q <= n_q + 4'h1;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  sequence head_s; hs && hdr; endsequence
  sequence byte_s; tx_valid && hx; endsequence
  sequence idle_s; !tx_valid && !rx_ready && !query_used; endsequence

  hold_stable_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("answer byte changed before acceptance");
  ans_head_a: assert property ($rose(tx_valid) |-> hdr)
    else $error("answer did not start with a header byte");
  head_stn_a: assert property (head_s |=> byte_s)
    else $error("station character missing after header");
  letter_pos_a: assert property (hs && !hdr && n_q == 4'h2 |->
    tx_data inside {8'h57, 8'h58, 8'h77, 8'h78})
    else $error("command letter not in fourth place");
  etx_pos_a: assert property (hs && tx_data == `SWM_ETX |->
    n_q == ((hd_q == `SWM_ACK) ? 4'h5 : 4'h9))
    else $error("end byte at wrong place in answer");
  err_hex_a: assert property (hs && !hdr && hd_q == `SWM_NAK && n_q >= 4'h5 && n_q <= 4'h8
    |-> hx)
    else $error("error code character is not upper-case hex");
  legal_byte_a: assert property (tx_valid |->
    hdr || hx || tx_data inside {8'h03, 8'h53, 8'h57, 8'h58, 8'h77, 8'h78})
    else $error("illegal byte in answer");
  tail_end_a: assert property (hs && tx_data == `SWM_ETX |=>
    byte_s or (##[0:1] !tx_valid))
    else $error("bad tail after end byte");
  rst_state_a: assert property ($rose(rst_b) |-> idle_s ##1 rx_ready)
    else $error("outputs not idle after reset");
endmodule // swm_monitor

bind swm_top swm_monitor mon_u (.sys_clk(sys_clk), .rst_b(rst_b), .rx_ready(rx_ready),
  .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .query_used(query_used));

// file: verif/swm_host.sv
// Host model that offers request bytes and collects answer bytes.
`timescale 1ns/100ps

module swm_host (
  input  wire        sys_clk,
  output logic [7:0] rx_data,
  output logic       rx_valid,
  input  wire        rx_ready,
  input  wire  [7:0] tx_data,
  input  wire        tx_valid,
  output logic       tx_ready,
  input  wire        stall,
  input  wire        slow
);
  logic [7:0] got[$];
  logic       full_seen = 1'b0;
  logic       tgl_q = 1'b0;

  initial begin
    rx_data  = 8'h00;
    rx_valid = 1'b0;
    tx_ready = 1'b0;
  end

  // The sink may stall, or take a byte only every second cycle to stretch the answer.
  always @(negedge sys_clk) begin
    tgl_q    <= ~tgl_q;
    tx_ready <= !stall && (!slow || tgl_q);
  end

  // Accepted answer bytes are queued; a refused request byte is noted.
  always @(posedge sys_clk) begin
    if (tx_valid && tx_ready)
      got.push_back(tx_data);
    if (rx_valid && !rx_ready)
      full_seen <= 1'b1;
  end

  // Bytes go back to back, each held until the edge that takes it; released data inverts.
  task automatic send_q(input logic [7:0] q[$]);
    foreach (q[i]) begin
      @(negedge sys_clk);
      rx_data  = q[i];
      rx_valid = 1'b1;
      do @(posedge sys_clk); while (rx_ready !== 1'b1);
    end
    @(negedge sys_clk);
    rx_valid = 1'b0;
    rx_data  = ~rx_data;
  endtask
endmodule // swm_host

// file: verif/testbench.sv
// Self-checking bench of the command interpreter driven by the host model.
`timescale 1ns/100ps
`include "swm_consts.vh"

module testbench;
  logic       sys_clk = 1'b0;
  logic       rst_b = 1'b0;
  logic [3:0] query_slot = 4'h0;
  logic       stall = 1'b0;
  logic       slow = 1'b0;
  wire  [7:0] rx_data, tx_data, query_count, query_name_len;
  wire        rx_valid, rx_ready, tx_valid, tx_ready, query_used, query_is_ind;
  int         failures = 0;
  int         samples_checked = 0;
  int         cycles = 0;
  int         s0 = 0;
  logic [7:0] frm[$];

  always #50 sys_clk = ~sys_clk;

  // A hang is cut short well above the fewer than two thousand cycles the run needs.
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 40000) begin
      failures++;
      report_and_stop();
    end
  end

  swm_top dut_u (.sys_clk(sys_clk), .rst_b(rst_b), .station_id(8'h01), .rx_data(rx_data),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .query_slot(query_slot), .query_used(query_used),
    .query_is_ind(query_is_ind), .query_count(query_count), .query_name_len(query_name_len));
  swm_host host_u (.sys_clk(sys_clk), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .stall(stall), .slow(slow));

  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask

  function automatic logic [7:0] hx(input logic [3:0] n);
    return (n < 4'hA) ? 8'h30 + n : 8'h37 + n;
  endfunction

  task automatic add(input string s);
    for (int i = 0; i < s.len(); i++) frm.push_back(s[i]);
  endtask

  // Frame check is the low byte of the sum since frame start, as two upper-case hex characters.
  task automatic add_sum(input logic [7:0] bad);
    logic [7:0] s;
    s = bad;
    for (int i = s0; i < frm.size(); i++) s += frm[i];
    frm.push_back(hx(s[7:4]));
    frm.push_back(hx(s[3:0]));
  endtask

  // Appends one request; a lowercase letter carries the check, spoilt by a non-zero bad.
  task automatic mk(input string st, input logic [7:0] lt, input string bd, input logic [7:0] bad);
    s0 = frm.size();
    frm.push_back(`SWM_ENQ);
    add(st);
    frm.push_back(lt);
    add(bd);
    frm.push_back(`SWM_EOT);
    if (lt[`SWM_LOWER_BIT]) add_sum(bad);
  endtask

  task automatic go();
    host_u.send_q(frm);
    frm = {};
  endtask

  // Waits for one whole answer and compares it byte by byte.
  task automatic ans(input logic [7:0] hd, input string s);
    logic [7:0] lt;
    lt = s[2];
    s0 = 0;
    frm = {};
    frm.push_back(hd);
    add(s);
    frm.push_back(`SWM_ETX);
    if (lt[`SWM_LOWER_BIT]) add_sum(8'h00);
    for (int i = 0; i < 3000 && host_u.got.size() < frm.size(); i++) @(posedge sys_clk);
    foreach (frm[i]) chk8("answer byte", frm[i], host_u.got.size() ? host_u.got.pop_front() : 8'hXX);
    frm = {};
  endtask

  task automatic q(input logic [3:0] sl, input logic u, input logic ind, input logic [7:0] c,
                   input logic [7:0] nl);
    @(negedge sys_clk);
    query_slot = sl;
    repeat (2) @(negedge sys_clk);
    chk8("slot used", u, query_used);
    if (u) begin
      chk8("slot kind", ind, query_is_ind);
      chk8("block count", c, query_count);
      chk8("name length", nl, query_name_len);
    end
  endtask

  // Two frames back to back against a stalled sink: the buffer must refuse, then drain.
  task automatic t_fill();
    stall = 1'b1;
    slow = 1'b1;
    mk("01", `SWM_CMD_REG, "03RSS0106%MW000", 8'h00);
    mk("01", `SWM_CMD_REG, "04RSS0106%MW000", 8'h00);
    fork
      go();
      begin
        repeat (400) @(negedge sys_clk);
        stall = 1'b0;
      end
    join
    chk8("buffer refused", 8'h01, host_u.full_seen);
    ans(`SWM_ACK, "01X03");
    ans(`SWM_ACK, "01X04");
    slow = 1'b0;
  endtask

  task automatic t_reg();
    mk("01", `SWM_CMD_REG, "01RSS0106%MW000", 8'h00);
    go();
    ans(`SWM_ACK, "01X01");
    q(4'h1, 1'b1, 1'b1, 8'h01, 8'h06);
    mk("01", `SWM_CMD_REG | 8'h20, "0FRSB06%MW1000A", 8'h00);
    go();
    ans(`SWM_ACK, "01x0F");
    q(4'hF, 1'b1, 1'b0, 8'h00, 8'h06);
    mk("01", `SWM_CMD_REG, "01RSB04%MW502", 8'h00);
    go();
    ans(`SWM_ACK, "01X01");
    q(4'h1, 1'b1, 1'b0, 8'h00, 8'h04);
  endtask

  task automatic t_reject();
    mk("01", `SWM_CMD_REG | 8'h20, "02RSS0106%MW000", 8'h01);
    go();
    ans(`SWM_NAK, "01x020001");
    q(4'h2, 1'b0, 1'b0, 8'h00, 8'h00);
    mk("01", `SWM_CMD_REG, "10RSS0106%MW000", 8'h00);
    go();
    ans(`SWM_NAK, "01X100003");
    q(4'h0, 1'b0, 1'b0, 8'h00, 8'h00);
    mk("02", `SWM_CMD_REG, "07RSS0106%MW000", 8'h00);
    go();
    repeat (200) @(posedge sys_clk);
    chk8("foreign answers", 8'h00, 8'(host_u.got.size()));
    q(4'h7, 1'b0, 1'b0, 8'h00, 8'h00);
  endtask

  // Counts just past and right at their limits, plus an unknown tag.
  task automatic t_limits();
    string bd[6] = '{"05RSS1106%MW000", "05RSS0111%MW000", "05RSS0100", "07RSX0106%MW000",
                     "05RSS1006%MW000", "06RSS0110%MW0000000000000"};
    string rs[6] = '{"01X050004", "01X050002", "01X050002", "01X070005", "01X05", "01X06"};
    for (int i = 0; i < 6; i++) begin
      mk("01", `SWM_CMD_REG, bd[i], 8'h00);
      go();
      ans(i < 4 ? `SWM_NAK : `SWM_ACK, rs[i]);
    end
    q(4'h7, 1'b0, 1'b0, 8'h00, 8'h00);
    q(4'h5, 1'b1, 1'b1, 8'h10, 8'h06);
    q(4'h6, 1'b1, 1'b1, 8'h01, 8'h10);
  endtask

  task automatic t_write();
    string d;
    d = "SB06%DW00080";
    mk("01", `SWM_CMD_WRITE | 8'h20, "SB06%DW00001AA15", 8'h00);
    go();
    ans(`SWM_ACK, "01wSB");
    repeat (240) d = {d, "F"};
    mk("01", `SWM_CMD_WRITE, d, 8'h00);
    go();
    ans(`SWM_ACK, "01WSB");
    d = {d, "FF"};
    mk("01", `SWM_CMD_WRITE, d, 8'h00);
    go();
    ans(`SWM_NAK, "01WSB0004");
  endtask

  task automatic report_and_stop();
    $display("failures %0d, samples_checked %0d", failures, samples_checked);
    if (failures == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    repeat (6) @(negedge sys_clk);
    rst_b = 1'b1;
    q(4'h5, 1'b0, 1'b0, 8'h00, 8'h00);
    t_fill();
    t_reg();
    t_reject();
    t_limits();
    t_write();
    report_and_stop();
  end
endmodule // testbench
